// ==== iex_defs.vh ====
// constants for the instruction execution subset block
`ifndef IEX_DEFS_VH
`define IEX_DEFS_VH
// operation codes on the decoded op port
`define IEX_OP_IDLE 5'h00
`define IEX_OP_POWERDOWN 5'h01
`define IEX_OP_INC_MEM 5'h02
`define IEX_OP_INC_WORK 5'h03
`define IEX_OP_JUMP 5'h04
`define IEX_OP_LOAD_MEM 5'h05
`define IEX_OP_LOAD_IMM 5'h06
`define IEX_OP_STORE 5'h07
`define IEX_OP_OR_MEM 5'h08
`define IEX_OP_OR_IMM 5'h09
`define IEX_OP_OR_TO_MEM 5'h0A
`define IEX_OP_RET 5'h0B
`define IEX_OP_RET_IMM 5'h0C
`define IEX_OP_INTERRUPT_EXIT 5'h0D
`define IEX_OP_RL 5'h0E
`define IEX_OP_RLA 5'h0F
`define IEX_OP_RLC 5'h10
`define IEX_OP_ROTATE_LEFT_VIA_CARRY_TO_WORK 5'h11
`define IEX_OP_RR 5'h12
`define IEX_OP_RRA 5'h13
`define IEX_OP_RRC 5'h14
// rotator mode codes
`define IEX_ROT_LEFT 2'h0
`define IEX_ROT_RIGHT 2'h1
`define IEX_ROT_LEFT_C 2'h2
`define IEX_ROT_RIGHT_C 2'h3
// field widths and reset values
`define IEX_PC_WIDTH 11
`define IEX_WORK_RESET 8'h00
`define IEX_PC_RESET 11'h000
`define IEX_IRQ_CTRL_RESET 8'h00
`define IEX_GIE_BIT 0
// cycles taken by a stack return
`define IEX_RET_CYCLES 2
`endif

// ==== iex_rotator.v ====
// byte rotator, plain or through carry
`timescale 1ns/1ps
`default_nettype none
module iex_rotator (
  // operand
  input wire [7:0] data_in,
  input wire carry_in,
  input wire [1:0] mode,
  // result
  output reg [7:0] data_out,
  output reg carry_out
);
`include "iex_defs.vh"
  // pick rotation by mode
  always @* begin
    carry_out = carry_in;
    case (mode)
      `IEX_ROT_LEFT: begin
        data_out = {data_in[6:0], data_in[7]};
      end
      `IEX_ROT_RIGHT: begin
        data_out = {data_in[0], data_in[7:1]};
      end
      `IEX_ROT_LEFT_C: begin
        data_out = {data_in[6:0], carry_in};
        carry_out = data_in[7];
      end
      default: begin
        data_out = {carry_in, data_in[7:1]};
        carry_out = data_in[0];
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== iex_logic_unit.v ====
// add-one and bitwise union unit with zero detect
`timescale 1ns/1ps
`default_nettype none
module iex_logic_unit (
  // operands
  input wire [7:0] mem_in,
  input wire [7:0] work_in,
  input wire [7:0] imm_in,
  input wire use_imm,
  input wire do_or,
  // result
  output wire [7:0] result,
  output wire zero
);
  // sum wraps at eight bits
  wire [7:0] inc_value;
  assign inc_value = mem_in + 8'h01;
  // union with memory or immediate
  wire [7:0] or_value;
  assign or_value = work_in | (use_imm ? imm_in : mem_in);
  assign result = do_or ? or_value : inc_value;
  assign zero = (result == 8'h00);
endmodule
`default_nettype wire

// ==== iex_exec.v ====
// execution unit for one subset of the 8-bit core instructions
`timescale 1ns/1ps
`default_nettype none
module iex_exec (
  // clock and reset
  input wire clk,
  input wire reset,
  input wire clk_en,
  // decoded instruction
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [7:0] imm_data,
  input wire [10:0] jump_addr,
  // data memory
  input wire [7:0] mem_rdata,
  output reg mem_we,
  output reg [7:0] mem_wdata,
  // return stack
  input wire [10:0] stack_top,
  output reg stack_pop,
  // program counter and sequencing
  output reg [10:0] pc,
  output wire busy,
  output reg flush,
  // core state
  output reg [7:0] work_register,
  output reg zero_flag,
  output reg carry_flag,
  output reg powerdown_flag,
  output reg watchdog_timeout_flag,
  output reg watchdog_clear,
  output reg [7:0] irq_control_reg,
  output reg sys_clock_off
);
`include "iex_defs.vh"
  // sequencer states, one-hot
  localparam ST_RUN = 3'b001;
  localparam ST_RET2 = 3'b010;
  localparam ST_HALT = 3'b100;
  reg [2:0] state;
  reg [2:0] next_state;
  // rotator wiring
  reg [1:0] rot_mode;
  wire [7:0] rot_data;
  wire rot_carry;
  // logic unit wiring
  wire [7:0] lu_result;
  wire lu_zero;
  reg lu_or;
  reg lu_imm;
  // instruction accepted this cycle
  wire take;
  assign take = clk_en & op_valid & (state == ST_RUN);
  // busy while in second return cycle or halted
  assign busy = (state != ST_RUN);
  iex_rotator u_rot (
    .data_in(mem_rdata),
    .carry_in(carry_flag),
    .mode(rot_mode),
    .data_out(rot_data),
    .carry_out(rot_carry)
  );
  iex_logic_unit u_lu (
    .mem_in(mem_rdata),
    .work_in(work_register),
    .imm_in(imm_data),
    .use_imm(lu_imm),
    .do_or(lu_or),
    .result(lu_result),
    .zero(lu_zero)
  );
  // choose functional unit modes from op
  always @* begin
    lu_or = 1'b0;
    lu_imm = 1'b0;
    rot_mode = `IEX_ROT_LEFT;
    case (op_code)
      `IEX_OP_OR_MEM: begin
        lu_or = 1'b1;
      end
      `IEX_OP_OR_IMM: begin
        lu_or = 1'b1;
        lu_imm = 1'b1;
      end
      `IEX_OP_OR_TO_MEM: begin
        lu_or = 1'b1;
      end
      `IEX_OP_RR, `IEX_OP_RRA: begin
        rot_mode = `IEX_ROT_RIGHT;
      end
      `IEX_OP_RLC, `IEX_OP_ROTATE_LEFT_VIA_CARRY_TO_WORK: begin
        rot_mode = `IEX_ROT_LEFT_C;
      end
      `IEX_OP_RRC: begin
        rot_mode = `IEX_ROT_RIGHT_C;
      end
      default: begin
        lu_or = 1'b0;
      end
    endcase
  end
  // memory write port, combinational strobe with data
  always @* begin
    mem_we = 1'b0;
    mem_wdata = mem_rdata;
    if (take) begin
      case (op_code)
        `IEX_OP_INC_MEM, `IEX_OP_OR_TO_MEM: begin
          mem_we = 1'b1;
          mem_wdata = lu_result;
        end
        `IEX_OP_STORE: begin
          mem_we = 1'b1;
          mem_wdata = work_register;
        end
        `IEX_OP_RL, `IEX_OP_RLC, `IEX_OP_RR, `IEX_OP_RRC: begin
          mem_we = 1'b1;
          mem_wdata = rot_data;
        end
        default: begin
          mem_we = 1'b0;
        end
      endcase
    end
  end
  // sequencer next state
  always @* begin
    next_state = state;
    stack_pop = 1'b0;
    case (state)
      ST_RUN: begin
        if (take) begin
          case (op_code)
            `IEX_OP_POWERDOWN: begin
              next_state = ST_HALT;
            end
            `IEX_OP_RET, `IEX_OP_RET_IMM, `IEX_OP_INTERRUPT_EXIT: begin
              stack_pop = 1'b1;
              next_state = ST_RET2;
            end
            default: begin
              next_state = ST_RUN;
            end
          endcase
        end
      end
      ST_RET2: begin
        if (clk_en) begin
          next_state = ST_RUN;
        end
      end
      ST_HALT: begin
        next_state = ST_HALT; // left only by reset
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end
  // state register
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_RUN;
    end else if (clk_en) begin
      state <= next_state;
    end
  end
  // program counter, work register and flags
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pc <= `IEX_PC_RESET;
      work_register <= `IEX_WORK_RESET;
      zero_flag <= 1'b0;
      carry_flag <= 1'b0;
      powerdown_flag <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
      watchdog_clear <= 1'b0;
      irq_control_reg <= `IEX_IRQ_CTRL_RESET;
      sys_clock_off <= 1'b0;
      flush <= 1'b0;
    end else if (clk_en) begin
      watchdog_clear <= 1'b0;
      flush <= 1'b0;
      if (take) begin
        // default step to next instruction
        pc <= pc + 11'h001;
        case (op_code)
          `IEX_OP_POWERDOWN: begin
            powerdown_flag <= 1'b1;
            watchdog_timeout_flag <= 1'b0;
            watchdog_clear <= 1'b1;
            sys_clock_off <= 1'b1;
            // data memory untouched here
          end
          `IEX_OP_INC_MEM: begin
            zero_flag <= lu_zero;
          end
          `IEX_OP_INC_WORK: begin
            work_register <= lu_result;
            zero_flag <= lu_zero;
          end
          `IEX_OP_JUMP: begin
            pc <= jump_addr;
            flush <= 1'b1;
          end
          `IEX_OP_LOAD_MEM: begin
            work_register <= mem_rdata;
          end
          `IEX_OP_LOAD_IMM: begin
            work_register <= imm_data;
          end
          `IEX_OP_OR_MEM, `IEX_OP_OR_IMM: begin
            work_register <= lu_result;
            zero_flag <= lu_zero;
          end
          `IEX_OP_OR_TO_MEM: begin
            zero_flag <= lu_zero;
          end
          `IEX_OP_RET: begin
            pc <= stack_top;
            flush <= 1'b1;
          end
          `IEX_OP_RET_IMM: begin
            pc <= stack_top;
            work_register <= imm_data;
            flush <= 1'b1;
          end
          `IEX_OP_INTERRUPT_EXIT: begin
            pc <= stack_top;
            irq_control_reg[`IEX_GIE_BIT] <= 1'b1;
            flush <= 1'b1;
          end
          `IEX_OP_RLA, `IEX_OP_RRA: begin
            work_register <= rot_data;
          end
          `IEX_OP_RLC, `IEX_OP_RRC: begin
            carry_flag <= rot_carry;
          end
          `IEX_OP_ROTATE_LEFT_VIA_CARRY_TO_WORK: begin
            work_register <= rot_data;
            carry_flag <= rot_carry;
          end
          default: begin
            flush <= 1'b0; // idle step, stores and the memory-only rotates RL and RR
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== iex_exec_props.sv ====
// assertion checker for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "iex_defs.vh"
module iex_exec_props (
  // clock and request
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic [10:0] jump_addr,
  // memory and stack
  input wire logic [7:0] mem_rdata,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic [10:0] stack_top,
  input wire logic stack_pop,
  // core state
  input wire logic [10:0] pc,
  input wire logic busy,
  input wire logic flush,
  input wire logic [7:0] work_register,
  input wire logic carry_flag,
  input wire logic powerdown_flag,
  input wire logic watchdog_timeout_flag,
  input wire logic watchdog_clear,
  input wire logic [7:0] irq_control_reg,
  input wire logic sys_clock_off
);
  // an operation is taken on this edge
  wire logic take = clk_en & op_valid & ~busy;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // a return is taken and pops the stack
  sequence s_pop;
    take && op_code inside {`IEX_OP_RET, `IEX_OP_RET_IMM, `IEX_OP_INTERRUPT_EXIT}
      ##0 stack_pop;
  endsequence
  // counter restored, then one dead cycle
  sequence s_refetch;
    pc == $past(stack_top) && flush && busy ##1 (!busy || !clk_en);
  endsequence
  property p_store;
    take && op_code == `IEX_OP_STORE |-> mem_we && mem_wdata == work_register;
  endproperty
  property p_jump;
    take && op_code == `IEX_OP_JUMP |=> pc == $past(jump_addr) && flush;
  endproperty
  property p_ret;
    s_pop |=> s_refetch;
  endproperty
  property p_interrupt_exit;
    take && op_code == `IEX_OP_INTERRUPT_EXIT |=> irq_control_reg[`IEX_GIE_BIT];
  endproperty
  property p_idle;
    take && op_code == `IEX_OP_IDLE
      |=> pc == 11'($past(pc) + 11'h001) && $stable(work_register);
  endproperty
  property p_pdown;
    take && op_code == `IEX_OP_POWERDOWN |=> powerdown_flag &&
      !watchdog_timeout_flag && watchdog_clear && sys_clock_off;
  endproperty
  property p_halt;
    sys_clock_off |-> busy && !mem_we && !stack_pop ##1 !watchdog_clear;
  endproperty
  property p_rl;
    take && op_code == `IEX_OP_RL |-> mem_we &&
      mem_wdata == {mem_rdata[6:0], mem_rdata[7]} ##1 $stable(carry_flag);
  endproperty
  property p_rrc;
    take && op_code == `IEX_OP_RRC |-> mem_wdata == {carry_flag,
      mem_rdata[7:1]} ##1 carry_flag == $past(mem_rdata[0]);
  endproperty
  a_store: assert property (p_store) else $error("store data wrong");
  a_jump: assert property (p_jump) else $error("jump target wrong");
  a_ret: assert property (p_ret) else $error("return wrong");
  a_interrupt_exit: assert property (p_interrupt_exit) else $error("enable not set");
  a_idle: assert property (p_idle) else $error("idle step wrong");
  a_pdown: assert property (p_pdown) else $error("halt flags");
  a_halt: assert property (p_halt) else $error("halt not held");
  a_rl: assert property (p_rl) else $error("rotate left wrong");
  a_rrc: assert property (p_rrc) else $error("rotate carry wrong");
endmodule
bind iex_exec iex_exec_props iex_exec_props_inst (.*);
`default_nettype wire

// ==== iex_mem_model.sv ====
// data memory byte and return stack partner model
`timescale 1ns/1ps
`default_nettype none
module iex_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // memory and stack side
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic stack_pop,
  output logic [7:0] mem_rdata,
  output logic [10:0] stack_top
);
  // one addressed byte; stack top steps on each pop
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_rdata <= 8'h00;
      stack_top <= 11'h2AA;
    end else begin
      if (mem_we)
        mem_rdata <= mem_wdata;
      if (stack_pop)
        stack_top <= stack_top + 11'h123;
    end
  end
endmodule
`default_nettype wire

// ==== iex_exec_test.sv ====
// self-checking testbench for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "iex_defs.vh"
module iex_exec_test;
  // design signals
  logic clk = 0, reset = 1, op_valid = 0, took = 0;
  logic [4:0] op_code = 0;
  logic [7:0] imm_data = 0, mem_rdata, mem_wdata, work_register;
  logic [7:0] irq_control_reg;
  logic [10:0] jump_addr = 0, stack_top, pc;
  logic mem_we, stack_pop, busy, flush, zero_flag, carry_flag;
  logic powerdown_flag, watchdog_timeout_flag, watchdog_clear, sys_clock_off;
  // expected state mirror
  logic [7:0] wk = 0, m = 0, t, seed = 8'h32;
  logic [10:0] epc = 0, st = 11'h2AA;
  logic z = 0, c = 0, b;
  logic [28:0] exp_q[$];
  integer miscompares = 0, n_checks = 0, i;
  logic clk_en = 1'b1;
  always #12.5 clk = ~clk;
  iex_exec iex_exec_inst (.*);
  iex_mem_model iex_mem_model_inst (.*);
  // compare and count
  task automatic check(input string nm, input logic [28:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // present one op at the falling edge, note its outcome
  task automatic run(input logic [4:0] op);
    seed = lfsr(seed);
    imm_data = seed;
    jump_addr = {seed[2:0], ~seed};
    op_code = op;
    op_valid = 1;
    // sometimes freeze one cycle with the op already shown
    if (seed[1:0] == 2'h0) begin
      clk_en = 0;
      @(negedge clk);
      clk_en = 1;
    end
    t = m + 8'h01;
    epc = epc + 11'h001;
    b = 0;
    case (op)
      `IEX_OP_INC_MEM: {m, z} = {t, t == 0};
      `IEX_OP_INC_WORK: {wk, z} = {t, t == 0};
      `IEX_OP_JUMP: epc = jump_addr;
      `IEX_OP_LOAD_MEM: wk = m;
      `IEX_OP_LOAD_IMM: wk = imm_data;
      `IEX_OP_STORE: m = wk;
      `IEX_OP_OR_MEM: {wk, z} = {wk | m, (wk | m) == 0};
      `IEX_OP_OR_IMM: {wk, z} = {wk | seed, (wk | seed) == 0};
      `IEX_OP_OR_TO_MEM: {m, z} = {wk | m, (wk | m) == 0};
      `IEX_OP_RET, `IEX_OP_INTERRUPT_EXIT: {b, epc, st} = {1'b1, st, st + 11'h123};
      `IEX_OP_RET_IMM: {b, epc, st, wk} = {1'b1, st, st + 11'h123, seed};
      `IEX_OP_RL: m = {m[6:0], m[7]};
      `IEX_OP_RLA: wk = {m[6:0], m[7]};
      `IEX_OP_RLC: {c, m} = {m, c};
      `IEX_OP_ROTATE_LEFT_VIA_CARRY_TO_WORK: {c, wk} = {m, c};
      `IEX_OP_RR: m = {m[0], m[7:1]};
      `IEX_OP_RRA: wk = {m[0], m[7:1]};
      `IEX_OP_RRC: {m, c} = {c, m};
      default: ;
    endcase
    exp_q.push_back({epc, wk, z, c, m});
    @(negedge clk);
    // dead cycle after a return
    if (b) begin
      op_valid = 0;
      @(negedge clk);
    end
  endtask
  // watch taken ops and compare their outcome
  always @(posedge clk)
    took <= op_valid & clk_en & ~busy & ~reset;
  always @(negedge clk) begin
    if (took && exp_q.size() > 0)
      check("state", {pc, work_register, zero_flag, carry_flag, mem_rdata},
        exp_q.pop_front());
  end
  // main sequence: every op except powerdown once, idle twice, then random ops, then halt
  initial begin
    repeat (5) @(negedge clk);
    reset = 0;
    check("reset", {pc, work_register, irq_control_reg}, 0);
    for (i = 0; i < 300; i++) begin
      seed = lfsr(seed);
      t = (i < 21) ? i : seed % 21;
      run((t == 1) ? 5'h00 : t[4:0]);
    end
    run(`IEX_OP_INTERRUPT_EXIT);
    check("gie", irq_control_reg[0], 1);
    run(`IEX_OP_POWERDOWN);
    op_code = `IEX_OP_STORE;
    op_valid = 1;
    repeat (3) @(negedge clk);
    check("halt", {pc, mem_rdata, powerdown_flag, watchdog_timeout_flag,
      sys_clock_off, busy}, {epc, m, 4'b1011});
    stop_test;
  end
  // hang guard
  initial begin
    #50us;
    miscompares++;
    stop_test;
  end
endmodule
`default_nettype wire
